// *** include/sbs_defs.svh ***
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH

// timing
`define SBS_CLK_PERIOD_NS       10
`define SBS_POR_PULSE_NS        75
`define SBS_POR_PULSE_CYC       ((`SBS_POR_PULSE_NS + `SBS_CLK_PERIOD_NS - 1) / `SBS_CLK_PERIOD_NS)

// register byte addresses
`define SBS_ADDR_IO_UPDATE      16'h0005
`define SBS_ADDR_CAL_SYNC       16'h0A02
`define SBS_ADDR_PROFILE_SEL    16'h0A0D
`define SBS_ADDR_MF_OE          16'h0200
`define SBS_ADDR_MF_OUT         16'h0201
`define SBS_ADDR_IRQ_MASK       16'h0202
`define SBS_ADDR_IRQ_MODE       16'h0203
`define SBS_ADDR_WDOG           16'h0204
`define SBS_ADDR_SYNC_PIN       16'h0205
`define SBS_ADDR_DIST_OE        16'h0400
`define SBS_ADDR_AUTO_SYNC      16'h0406
`define SBS_ADDR_REF_CFG        16'h0500
`define SBS_ADDR_STRAP          16'h0D00

// address spaces (upper byte)
`define SBS_SPACE_DPLL          8'h03
`define SBS_SPACE_DIST          8'h04
`define SBS_SPACE_REF           8'h05

// field positions
`define SBS_BIT_IO_UPDATE       0
`define SBS_BIT_CAL             0
`define SBS_BIT_SYNC            1
`define SBS_BIT_SYNC_PIN_EN     3
`define SBS_BIT_AUTO_PROFILE    0
`define SBS_DIST_OE_W           4

// reset values
`define SBS_CTRL_RESET          8'h00

`endif

// *** include/sbs_pkg.sv ***
package sbs_pkg;

  typedef enum logic [1:0] {
    POR_WAIT,
    POR_PULSE,
    POR_DONE
  } sbs_por_e;

  typedef struct packed {
    logic [7:0] cal_sync;
    logic [7:0] profile_sel;
    logic [7:0] mf_oe;
    logic [7:0] mf_out;
    logic [7:0] irq_mask;
    logic [7:0] irq_mode;
    logic [7:0] wdog;
    logic [7:0] sync_pin;
    logic [7:0] dist_oe;
    logic [7:0] auto_sync;
    logic [7:0] ref_cfg;
  } sbs_ctrl_s;

  typedef struct packed {
    logic       sup_hi_s1;
    logic       sup_hi_s2;
    logic       sup_core_s1;
    logic       sup_core_s2;
    sbs_por_e   state;
    logic [3:0] cnt;
  } sbs_por_s;

  typedef struct packed {
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] pin_prev;
    logic       rstpin_s1;
    logic       rstpin_s2;
    logic       rst_q;
    logic       lock_q;
    logic [7:0] strap;
    sbs_ctrl_s  stg;
    sbs_ctrl_s  act;
    logic       upd;
    logic       eeprom_load;
    logic       profile_start;
    logic       acquire;
    logic       sync;
    logic [2:0] space_wr;
    logic [7:0] rdata;
  } sbs_state_s;

endpackage

// *** core/sbs_por.sv ***
`timescale 1ns/1ns
`include "sbs_defs.svh"

module sbs_por (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic supply_high_ok_i,
  input  wire logic supply_core_ok_i,
  output logic      por_o
);
  import sbs_pkg::*;

  localparam logic [3:0] PULSE_LAST = 4'(`SBS_POR_PULSE_CYC - 1);

  sbs_por_s r;
  sbs_por_s next_r;
  logic     both_ok;

  assign both_ok = r.sup_hi_s2 & r.sup_core_s2;
  assign por_o   = (r.state == POR_PULSE);

  always_comb begin
    next_r             = r;
    next_r.sup_hi_s1   = supply_high_ok_i;
    next_r.sup_hi_s2   = r.sup_hi_s1;
    next_r.sup_core_s1 = supply_core_ok_i;
    next_r.sup_core_s2 = r.sup_core_s1;
    case (r.state)
      POR_WAIT: begin
        if (both_ok) begin
          next_r.state = POR_PULSE;
          next_r.cnt   = 4'h0;
        end
      end
      POR_PULSE: begin
        if (r.cnt == PULSE_LAST) begin
          next_r.state = POR_DONE;
        end else begin
          next_r.cnt = r.cnt + 4'h1;
        end
      end
      POR_DONE: begin
        // re-arm if a supply drops
        if (!both_ok) begin
          next_r.state = POR_WAIT;
        end
      end
      default: begin
        next_r.state = POR_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule

// *** core/sbs_startup.sv ***
// Function
// - power-up reset pulse of 80 ns (75 ns rounded up to 8 cycles)
// - power-up reset independent of reset pin
// - pins high-impedance within 45 ns of reset
// - pins inputs during reset, captured at release
// - strap bit n equals pin n
// - low strap bits 000 select SPI
// - nonzero low bits select I2C address
// - high strap bits zero skip EEPROM load
// - nonzero high bits start EEPROM load
// - update bit commits staged settings
// - pins default unassigned high-impedance inputs
// - interrupts masked, open-drain mode by default
// - watchdog disabled after reset
// - distribution outputs disabled after reset
// - manual profile: acquire after final update
// - automatic profile: start selected detectors
// - sync bit or pin starts outputs
// - DPLL, distribution, reference address spaces
`timescale 1ns/1ns
`include "sbs_defs.svh"

module sbs_startup (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       supply_high_ok_i,
  input  wire logic       supply_core_ok_i,
  input  wire logic       reset_pin_i,
  input  wire logic [7:0] mf_pins_i,
  output logic      [7:0] mf_pins_o,
  output logic      [7:0] mf_pins_oe_n_o,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic      [7:0] strap_capture_value_o,
  output logic            spi_mode_o,
  output logic      [2:0] i2c_addr_low_o,
  output logic            eeprom_load_o,
  output logic      [4:0] eeprom_condition_o,
  output logic            device_reset_o,
  output logic            io_update_o,
  output logic            system_clock_input_cal_o,
  input  wire logic       dpll_locked_i,
  input  wire logic       detect_done_i,
  output logic            profile_start_o,
  output logic      [7:0] profile_sel_o,
  output logic            dpll_acquire_o,
  output logic            dist_sync_o,
  output logic      [3:0] dist_oe_o,
  output logic      [7:0] irq_mask_o,
  output logic            irq_od_mode_o,
  output logic            watchdog_en_o,
  output logic      [2:0] space_wr_o
);
  import sbs_pkg::*;

  sbs_state_s r;
  sbs_state_s next_r;
  logic       por;
  logic       rst_any;
  logic       wr_ok;
  logic       strap_take;

  logic       hit_update;
  logic       hit_strap;
  logic       auto_profile;

  logic       sync_pin_en;
  logic       sync_pin_now;
  logic       sync_pin_was;
  logic       sync_pin_edge;
  logic       sync_bit_drop;
  logic       lock_rise;
  logic [2:0] sync_idx;

  // staged register map; unmapped addresses are left alone
  function automatic sbs_ctrl_s ctrl_write(input sbs_ctrl_s c, input logic [15:0] a,
                                           input logic [7:0] d);
    sbs_ctrl_s o;
    o = c;
    case (a)
      `SBS_ADDR_CAL_SYNC:    o.cal_sync    = d;
      `SBS_ADDR_PROFILE_SEL: o.profile_sel = d;
      `SBS_ADDR_MF_OE:       o.mf_oe       = d;
      `SBS_ADDR_MF_OUT:      o.mf_out      = d;
      `SBS_ADDR_IRQ_MASK:    o.irq_mask    = d;
      `SBS_ADDR_IRQ_MODE:    o.irq_mode    = d;
      `SBS_ADDR_WDOG:        o.wdog        = d;
      `SBS_ADDR_SYNC_PIN:    o.sync_pin    = d;
      `SBS_ADDR_DIST_OE:     o.dist_oe     = d;
      `SBS_ADDR_AUTO_SYNC:   o.auto_sync   = d;
      `SBS_ADDR_REF_CFG:     o.ref_cfg     = d;
      default:               o             = c;
    endcase
    return o;
  endfunction

  // unmapped and write-only addresses read as zero
  function automatic logic [7:0] ctrl_read(input sbs_ctrl_s c, input logic [15:0] a);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      `SBS_ADDR_CAL_SYNC:    d = c.cal_sync;
      `SBS_ADDR_PROFILE_SEL: d = c.profile_sel;
      `SBS_ADDR_MF_OE:       d = c.mf_oe;
      `SBS_ADDR_MF_OUT:      d = c.mf_out;
      `SBS_ADDR_IRQ_MASK:    d = c.irq_mask;
      `SBS_ADDR_IRQ_MODE:    d = c.irq_mode;
      `SBS_ADDR_WDOG:        d = c.wdog;
      `SBS_ADDR_SYNC_PIN:    d = c.sync_pin;
      `SBS_ADDR_DIST_OE:     d = c.dist_oe;
      `SBS_ADDR_AUTO_SYNC:   d = c.auto_sync;
      `SBS_ADDR_REF_CFG:     d = c.ref_cfg;
      default:               d = 8'h00;
    endcase
    return d;
  endfunction

  // one-hot strobe per address space
  function automatic logic [2:0] space_of(input logic [15:0] a);
    return {a[15:8] == `SBS_SPACE_REF, a[15:8] == `SBS_SPACE_DIST,
            a[15:8] == `SBS_SPACE_DPLL};
  endfunction

  // edge of a level against its value one cycle earlier
  function automatic logic went_high(input logic now_v, input logic was_v);
    return now_v & ~was_v;
  endfunction

  function automatic logic went_low(input logic now_v, input logic was_v);
    return ~now_v & was_v;
  endfunction

  // pulse width is counted in system clock cycles
  // power-up reset runs on supplies alone
  sbs_por u_por (
    .clk_i            (clk_i),
    .srst_i           (srst_i),
    .supply_high_ok_i (supply_high_ok_i),
    .supply_core_ok_i (supply_core_ok_i),
    .por_o            (por)
  );

  // any reset: bench reset, power-up pulse or synchronised pin
  assign rst_any    = srst_i | por | r.rstpin_s2;
  assign wr_ok      = reg_wr_i & ~rst_any;
  // first cycle with every reset gone
  assign strap_take = went_low(rst_any, r.rst_q);

  assign hit_update   = (reg_addr_i == `SBS_ADDR_IO_UPDATE);
  assign hit_strap    = (reg_addr_i == `SBS_ADDR_STRAP);
  assign auto_profile = r.act.ref_cfg[`SBS_BIT_AUTO_PROFILE];

  // a pin driven by the chip itself must not fire a sync
  assign sync_idx      = r.act.sync_pin[2:0];
  assign sync_pin_en   = r.act.sync_pin[`SBS_BIT_SYNC_PIN_EN] & ~r.act.mf_oe[sync_idx];
  assign sync_pin_now  = r.pin_s2[sync_idx];
  assign sync_pin_was  = r.pin_prev[sync_idx];
  assign sync_pin_edge = sync_pin_en & went_high(sync_pin_now, sync_pin_was);
  // update clears a set sync bit
  assign sync_bit_drop = went_low(r.stg.cal_sync[`SBS_BIT_SYNC], r.act.cal_sync[`SBS_BIT_SYNC]);
  // lock edge when auto sync is on
  assign lock_rise     = r.act.auto_sync[0] & went_high(dpll_locked_i, r.lock_q);

  always_comb begin
    next_r               = r;
    next_r.pin_s1        = mf_pins_i;
    next_r.pin_s2        = r.pin_s1;
    next_r.pin_prev      = r.pin_s2;
    next_r.rstpin_s1     = reset_pin_i;
    next_r.rstpin_s2     = r.rstpin_s1;
    next_r.rst_q         = rst_any;
    next_r.lock_q        = dpll_locked_i;
    // strobes last one cycle unless set again below
    next_r.upd           = 1'b0;
    next_r.eeprom_load   = 1'b0;
    next_r.profile_start = 1'b0;
    next_r.acquire       = 1'b0;
    next_r.sync          = 1'b0;
    next_r.space_wr      = 3'h0;

    // reads show staged values, not committed ones
    if (reg_rd_i) begin
      if (hit_strap) begin
        next_r.rdata = r.strap;
      end else begin
        next_r.rdata = ctrl_read(r.stg, reg_addr_i);
      end
    end

    // pins as seen two cycles ago, past the synchronisers
    // capture pins when reset is removed
    if (strap_take) begin
      next_r.strap = r.pin_s2;
      next_r.eeprom_load = |r.pin_s2[7:3];
    end

    if (wr_ok) begin
      next_r.space_wr = space_of(reg_addr_i);
      if (hit_update) begin
        next_r.upd = reg_wdata_i[`SBS_BIT_IO_UPDATE];
      end else begin
        next_r.stg = ctrl_write(r.stg, reg_addr_i, reg_wdata_i);
      end
    end

    // outputs all move on this one edge
    // commit staged settings
    if (r.upd) begin
      next_r.act = r.stg;
      if (sync_bit_drop) begin
        next_r.sync = 1'b1;
      end
      if (r.stg.ref_cfg[`SBS_BIT_AUTO_PROFILE]) begin
        next_r.profile_start = |r.stg.profile_sel;
      end else begin
        next_r.acquire = 1'b1;
      end
    end

    if (detect_done_i & auto_profile) begin
      next_r.acquire = 1'b1;
    end

    if (sync_pin_edge | lock_rise) begin
      next_r.sync = 1'b1;
    end

    // reset last, so it wins over every path above
    if (rst_any) begin
      next_r.stg           = '0;
      next_r.act           = '0;
      next_r.upd           = 1'b0;
      next_r.profile_start = 1'b0;
      next_r.acquire       = 1'b0;
      next_r.sync          = 1'b0;
      next_r.space_wr      = 3'h0;
      next_r.rdata         = 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // release pins as soon as reset appears
  assign mf_pins_oe_n_o = ~r.act.mf_oe | {8{rst_any}};
  assign mf_pins_o      = r.act.mf_out;

  assign strap_capture_value_o = r.strap;
  assign spi_mode_o            = (r.strap[2:0] == 3'h0);
  assign i2c_addr_low_o        = r.strap[2:0];
  assign eeprom_load_o         = r.eeprom_load;
  assign eeprom_condition_o    = r.strap[7:3];

  assign device_reset_o        = r.rst_q;
  assign io_update_o           = r.upd;
  assign system_clock_input_cal_o          = r.act.cal_sync[`SBS_BIT_CAL];
  assign profile_start_o       = r.profile_start;
  assign profile_sel_o         = r.act.profile_sel;
  assign dpll_acquire_o        = r.acquire;
  assign dist_sync_o           = r.sync;

  assign dist_oe_o             = r.act.dist_oe[`SBS_DIST_OE_W-1:0];
  assign irq_mask_o            = r.act.irq_mask;
  assign irq_od_mode_o         = ~r.act.irq_mode[0];
  assign watchdog_en_o         = r.act.wdog[0];
  assign space_wr_o            = r.space_wr;
  assign reg_rdata_o           = r.rdata;

endmodule

// *** verification/sbs_startup_monitor.sv ***
`timescale 1ns/1ns
module sbs_startup_monitor (
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic        reg_wr_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic [7:0]  mf_pins_oe_n_o,
  input wire logic [7:0]  strap_capture_value_o,
  input wire logic        spi_mode_o,
  input wire logic [2:0]  i2c_addr_low_o,
  input wire logic        eeprom_load_o,
  input wire logic [4:0]  eeprom_condition_o,
  input wire logic        device_reset_o,
  input wire logic        io_update_o,
  input wire logic [3:0]  dist_oe_o,
  input wire logic [7:0]  irq_mask_o,
  input wire logic        irq_od_mode_o,
  input wire logic        watchdog_en_o,
  input wire logic [2:0]  space_wr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic [7:0] s;
  assign s = strap_capture_value_o;
  a_pins_hiz_rst: assert property (device_reset_o |-> mf_pins_oe_n_o == 8'hFF)
    else $error("pins driven in reset");
  a_strap_held: assert property (!device_reset_o && !$past(device_reset_o) && !$past(srst_i)
    && !$past(srst_i, 2) |-> $stable(s)) else $error("strap changed");
  a_serial_mode: assert property ($fell(device_reset_o) |=>
    spi_mode_o == (s[2:0] == 3'h0) && i2c_addr_low_o == s[2:0]) else $error("serial mode");
  a_load_start: assert property ($fell(device_reset_o) |->
    eeprom_load_o == (s[7:3] != 5'h00)) else $error("load start");
  a_load_cond: assert property (eeprom_load_o |-> eeprom_condition_o == s[7:3]
    ##1 !eeprom_load_o) else $error("load condition");
  a_rst_defaults: assert property (device_reset_o |-> irq_mask_o == 8'h00
    && irq_od_mode_o && !watchdog_en_o && dist_oe_o == 4'h0) else $error("defaults");
  a_update_pulse: assert property (reg_wr_i && !device_reset_o && reg_addr_i == 16'h0005
    && reg_wdata_i[0] |=> io_update_o ##1 !io_update_o) else $error("io update");
  a_space_dist: assert property (reg_wr_i && !device_reset_o && reg_addr_i[15:8] == 8'h04
    |=> space_wr_o == 3'b010) else $error("space map");
  cover property (eeprom_load_o);
  cover property (io_update_o);
  cover property (space_wr_o == 3'b010);
endmodule

// *** verification/sbs_host_model.sv ***
`timescale 1ns/1ns
module sbs_host_model (
  input  wire logic  clk_i,
  output logic       reg_wr_o,
  output logic       reg_rd_o,
  output logic [15:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  logic [7:0] exp_q[$];
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 16'h0000;
    reg_wdata_o = 8'h00;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {reg_addr_o, reg_wdata_o, reg_wr_o} = {a, d, 1'b1};
    @(negedge clk_i);
    {reg_addr_o, reg_wdata_o, reg_wr_o} = {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk_i);
    {reg_addr_o, reg_rd_o} = {a, 1'b1};
    exp_q.push_back(e);
    @(negedge clk_i);
    {reg_addr_o, reg_rd_o} = {~a, 1'b0};
  endtask
  task automatic upd();
    wr(16'h0005, 8'h01);
    repeat (3) @(negedge clk_i);
  endtask
  task automatic boot();
    wr(16'h0101, 8'h0A);
    upd();
  endtask
  task automatic cal_set(input logic [7:0] d);
    wr(16'h0A02, d);
    upd();
  endtask
endmodule

// *** verification/tb_sbs_startup.sv ***
`timescale 1ns/1ns
module tb_sbs_startup;
  logic clk_i, srst_i, supply_high_ok_i, supply_core_ok_i, reset_pin_i, reg_wr_i, reg_rd_i;
  logic dpll_locked_i, detect_done_i, spi_mode_o, eeprom_load_o, device_reset_o, io_update_o;
  logic system_clock_input_cal_o, profile_start_o, dpll_acquire_o, dist_sync_o, irq_od_mode_o, watchdog_en_o;
  logic [15:0] reg_addr_i;
  logic [7:0]  mf_pins_i, mf_pins_o, mf_pins_oe_n_o, reg_wdata_i, reg_rdata_o, profile_sel_o;
  logic [7:0]  strap_capture_value_o, irq_mask_o, pins, v, r, e;
  logic [4:0]  eeprom_condition_o;
  logic [3:0]  dist_oe_o;
  logic [2:0]  i2c_addr_low_o, space_wr_o;
  logic        rd_seen;
  logic [31:0] seed;
  int          n_errors, tests_run, cyc, n, a, e_eld, n_eld, n_acq, n_sync, n_ps;
  // pin level: pad driver where enabled, board strap resistors elsewhere
  assign mf_pins_i = (mf_pins_oe_n_o & pins) | (~mf_pins_oe_n_o & mf_pins_o);
  sbs_startup i_dut (.clk_i, .srst_i, .supply_high_ok_i, .supply_core_ok_i, .reset_pin_i,
    .mf_pins_i, .mf_pins_o, .mf_pins_oe_n_o, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .strap_capture_value_o, .spi_mode_o, .i2c_addr_low_o, .eeprom_load_o,
    .eeprom_condition_o, .device_reset_o, .io_update_o, .system_clock_input_cal_o, .dpll_locked_i,
    .detect_done_i, .profile_start_o, .profile_sel_o, .dpll_acquire_o, .dist_sync_o,
    .dist_oe_o, .irq_mask_o, .irq_od_mode_o, .watchdog_en_o, .space_wr_o);
  sbs_host_model i_host (.clk_i, .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] s);
    tests_run++;
    if (s !== x) begin
      $display("Error: %s expected %h seen %h", nm, x, s);
      n_errors++;
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    rd_seen <= reg_rd_i;
    n_eld <= n_eld + int'(eeprom_load_o === 1'b1);
    n_acq <= n_acq + int'(dpll_acquire_o === 1'b1);
    n_sync <= n_sync + int'(dist_sync_o === 1'b1);
    n_ps <= n_ps + int'(profile_start_o === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      results();
    end
  end
  always @(negedge clk_i) begin
    if (rd_seen === 1'b1) begin
      e = i_host.exp_q.pop_front();
      chk("reg_rdata_o", e, reg_rdata_o);
    end
  end
  initial begin
    seed = 32'h5680;
    {srst_i, supply_high_ok_i, supply_core_ok_i, reset_pin_i} = 4'h8;
    {dpll_locked_i, detect_done_i, pins} = 10'h000;
    r = 8'($random(seed)) | 8'h09;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i) srst_i = 1'b0;
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 8'h00 : (k == 1) ? r : 8'hF8;
      pins = v;
      n = 0;
      if (k == 0) begin
        repeat (3) @(negedge clk_i);
        supply_core_ok_i = 1'b1;
        @(negedge clk_i) supply_high_ok_i = 1'b1;
      end else begin
        reset_pin_i = 1'b1;
        repeat (4) @(negedge clk_i);
        chk("mf_pins_oe_n_o", 8'hFF, mf_pins_oe_n_o);
        reset_pin_i = 1'b0;
      end
      repeat (20) begin
        @(negedge clk_i);
        n += int'(device_reset_o === 1'b1);
      end
      if (k == 0) chk("por_cycles_in_range", 8'h01, 8'(n >= 8 && n <= 12));
      e_eld += int'(v[7:3] != 5'h00);
      chk("eeprom_loads", 8'(e_eld), 8'(n_eld));
      chk("eeprom_condition_o", 8'(v[7:3]), 8'(eeprom_condition_o));
      chk("spi_mode_o", 8'(v[2:0] == 3'h0), 8'(spi_mode_o));
      chk("i2c_addr_low_o", 8'(v[2:0]), 8'(i2c_addr_low_o));
      i_host.rd(16'h0D00, v);
      pins = ~v;
      repeat (4) @(negedge clk_i);
      i_host.rd(16'h0D00, v);
    end
    $display("test straps done");
    i_host.boot();
    i_host.cal_set(8'h01);
    chk("system_clock_input_cal_o", 8'h01, 8'(system_clock_input_cal_o));
    i_host.cal_set(8'h00);
    chk("system_clock_input_cal_o", 8'h00, 8'(system_clock_input_cal_o));
    i_host.cal_set(8'h02);
    i_host.cal_set(8'h00);
    chk("dist_syncs", 8'h01, 8'(n_sync));
    chk("irq_mask_o", 8'h00, irq_mask_o);
    chk("irq_od_mode_o", 8'h01, 8'(irq_od_mode_o));
    chk("watchdog_en_o", 8'h00, 8'(watchdog_en_o));
    chk("mf_pins_oe_n_o", 8'hFF, mf_pins_oe_n_o);
    i_host.wr(16'h0400, 8'h0A);
    i_host.wr(16'h0204, 8'h01);
    i_host.wr(16'h0201, r);
    i_host.wr(16'h0200, 8'hFF);
    i_host.wr(16'h0300, r);
    i_host.rd(16'h0400, 8'h0A);
    i_host.rd(16'h0777, 8'h00);
    i_host.rd(16'h0A0D, 8'h00);
    chk("dist_oe_o", 8'h00, 8'(dist_oe_o));
    i_host.upd();
    chk("dist_oe_o", 8'h0A, 8'(dist_oe_o));
    chk("watchdog_en_o", 8'h01, 8'(watchdog_en_o));
    chk("mf_pins_o", r, mf_pins_o);
    chk("mf_pins_oe_n_o", 8'h00, mf_pins_oe_n_o);
    chk("dpll_acquires", 8'h06, 8'(n_acq));
    $display("test registers done");
    i_host.wr(16'h0500, 8'h01);
    i_host.wr(16'h0A0D, 8'h03);
    i_host.upd();
    chk("profile_sel_o", 8'h03, profile_sel_o);
    chk("profile_starts", 8'h01, 8'(n_ps));
    a = n_acq;
    @(negedge clk_i) detect_done_i = 1'b1;
    @(negedge clk_i) detect_done_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk("dpll_acquires", 8'(a + 1), 8'(n_acq));
    $display("test profiles done");
    i_host.wr(16'h0205, 8'h08);
    i_host.wr(16'h0200, 8'hFE);
    i_host.wr(16'h0406, 8'h01);
    pins = 8'h00;
    i_host.upd();
    chk("mf_pins_oe_n_o", 8'h01, mf_pins_oe_n_o);
    a = n_sync;
    pins = r;
    repeat (5) @(negedge clk_i);
    chk("dist_syncs", 8'(a + 1), 8'(n_sync));
    dpll_locked_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk("dist_syncs", 8'(a + 2), 8'(n_sync));
    $display("test sync done");
    results();
  end
endmodule
bind sbs_startup sbs_startup_monitor i_mon (.clk_i, .srst_i, .reg_wr_i, .reg_addr_i,
  .reg_wdata_i, .mf_pins_oe_n_o, .strap_capture_value_o, .spi_mode_o, .i2c_addr_low_o,
  .eeprom_load_o, .eeprom_condition_o, .device_reset_o, .io_update_o, .dist_oe_o,
  .irq_mask_o, .irq_od_mode_o, .watchdog_en_o, .space_wr_o);
